// File: common/pin_event_pkg.sv
/*
  Shared constants and types for the pin event unit: register offsets,
  mode encodings, reset values and the AXI4-Lite response codes.
  Assumes a 32-bit AXI4-Lite register bus and a single 200 MHz clock.
*/
package pin_event_pkg;

  // Geometry
  localparam int NUM_CHAN     = 8;
  localparam int NUM_PINS     = 64;
  localparam int SEL_W        = 6;
  localparam int ADDR_W       = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_SEL_LO   = 8'h00;  // Pin selection, channels 0..3
  localparam logic [7:0] OFS_SEL_HI   = 8'h04;  // Pin selection, channels 4..7
  localparam logic [7:0] OFS_LEVEL    = 8'h08;  // 1 = level sensitive
  localparam logic [7:0] OFS_RISE_EN  = 8'h0C;  // Rising edge or high-active enable
  localparam logic [7:0] OFS_FALL_EN  = 8'h10;  // Falling edge or low-active enable
  localparam logic [7:0] OFS_STATUS   = 8'h14;  // Read: channel lines, write 1 clears edge flags
  localparam logic [7:0] OFS_WAKE_EN  = 8'h18;  // Channel wake enables
  localparam logic [7:0] OFS_PM_CTRL  = 8'h1C;  // Bit0 match mode, bit1 event enable
  localparam logic [7:0] OFS_PM_SRC   = 8'h20;  // Read only: registered term outputs
  localparam logic [7:0] OFS_PM_CFG0  = 8'h24;  // Term requirement codes, 4 bits per pin
  localparam logic [7:0] OFS_PM_CFG1  = 8'h28;  // Codes for odd terms, 4 bits per pin
  localparam logic [7:0] OFS_PM_TERM  = 8'h2C;  // Term enable mask
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;  // Sticky event status, read only
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h34;  // Write 1 clears status
  localparam logic [7:0] OFS_IRQ_EN   = 8'h38;  // Summary interrupt enables
  localparam logic [7:0] OFS_PINS     = 8'h3C;  // Synchronised pin levels

  // Reset values
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;

  // Pattern condition codes (per pin, per term)
  typedef enum logic [2:0] {
    COND_DONT_CARE,
    COND_HIGH,
    COND_LOW,
    COND_RISE,
    COND_FALL,
    COND_ANY_EDGE
  } cond_e;

  // Response codes
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;

  // Packed view of the synchronised pins
  typedef struct packed {
    logic [NUM_CHAN-1:0] level;   // Current level
    logic [NUM_CHAN-1:0] rise;    // Rising edge this cycle
    logic [NUM_CHAN-1:0] fall;    // Falling edge this cycle
  } pin_view_s;

endpackage : pin_event_pkg

// File: core/pin_sync.sv
/*
  Two-stage synchroniser with edge extraction for the selected pins.
  Assumes inputs may be asynchronous to aclk; only stage two is observed.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Raw pins
  input  wire logic [WIDTH-1:0] pin_in,
  // Synchronised view
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_r;   // First stage, read only by stage two
  logic [WIDTH-1:0] sync_r;   // Second stage
  logic [WIDTH-1:0] prev_r;   // Previous synchronised level
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;
  logic [WIDTH-1:0] prev_nxt;

  // Next values of the chain
  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // Register the chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // Edges from stage two only
  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;

endmodule : pin_sync

// File: core/pin_event_unit.sv
/*
  Pin event unit: eight pin interrupt channels or a pattern match engine,
  registers over AXI4-Lite, per-channel interrupt lines, a wake request,
  a cpu_wake_event pulse and a summary interrupt.
  Assumes pins arrive from the system_config_block as a flat vector and that
  the cpu_interrupt_controller takes one line per channel.
*/
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - Eight channels, edge or level sensitive
// - Each channel drives its own interrupt line
// - Edge mode: rise, fall, or both
// - Level mode: active high or low
// - Channels can wake from low power
// - Pattern terms test levels and transitions
// - Each product term raises its own request
// - Optional event pulse when a match starts with no term active
// - Pattern engine never requests wake-up
// - Reads answer in one cycle, writes in two
// - Pin per channel chosen by selection
module pin_event_unit #(
  parameter int NUM_CHAN = pin_event_pkg::NUM_CHAN,
  parameter int NUM_PINS = pin_event_pkg::NUM_PINS
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // Pins from the system_config_block
  input  wire logic [NUM_PINS-1:0] pin_bus,
  // AXI4-Lite write address
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Towards the cpu_interrupt_controller
  output logic [NUM_CHAN-1:0]      chan_irq,
  output logic                     wake_req,
  output logic                     cpu_wake_event,
  output logic                     irq
);

  // Bits per pin selection
  localparam int SW = pin_event_pkg::SEL_W;

  // Software state
  logic [NUM_CHAN*SW-1:0] sel_r, sel_nxt;         // Pin selection per channel
  logic [NUM_CHAN-1:0]    level_r, level_nxt;     // 1 = level mode
  logic [NUM_CHAN-1:0]    rise_en_r, rise_en_nxt; // Rise or high-active
  logic [NUM_CHAN-1:0]    fall_en_r, fall_en_nxt; // Fall or low-active
  logic [NUM_CHAN-1:0]    wake_en_r, wake_en_nxt; // Wake enables
  logic [1:0]             pm_ctrl_r, pm_ctrl_nxt; // Match mode, event enable
  logic [31:0]            pm_cfg_r, pm_cfg_nxt;   // 4-bit codes: term t, pin p
  logic [31:0]            pm_cfg1_r, pm_cfg1_nxt; // Second half of codes
  logic [NUM_CHAN-1:0]    pm_term_r, pm_term_nxt; // Term enables
  logic [NUM_CHAN-1:0]    flag_r, flag_nxt;       // Latched edge requests
  logic [NUM_CHAN-1:0]    ist_r, ist_nxt;         // Sticky summary status
  logic [NUM_CHAN-1:0]    ien_r, ien_nxt;         // Summary enables
  logic                   event_r, event_nxt;     // Event pulse
  logic [NUM_CHAN-1:0]    term_r, term_nxt;       // Registered term outputs

  // Bus state
  logic                   aw_got_r, aw_got_nxt;
  logic                   w_got_r, w_got_nxt;
  logic [7:0]             awaddr_r, awaddr_nxt;
  logic [31:0]            wdata_r, wdata_nxt;
  logic                   bvalid_r, bvalid_nxt;
  logic [1:0]             bresp_r, bresp_nxt;
  logic                   rvalid_r, rvalid_nxt;
  logic [31:0]            rdata_r, rdata_nxt;
  logic [1:0]             rresp_r, rresp_nxt;

  // Combinational helpers
  logic [NUM_CHAN-1:0]    sel_pins;
  pin_event_pkg::pin_view_s pv;
  logic [NUM_CHAN-1:0]    edge_hit;
  logic [NUM_CHAN-1:0]    lvl_hit;
  logic [NUM_CHAN-1:0]    term_hit;
  logic                   wr_fire;
  logic [NUM_CHAN-1:0]    flag_clr;
  logic [NUM_CHAN-1:0]    ist_clr;
  logic [3:0]             cond_code;

  // Register decode, shared by read and write paths
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a[1:0] == 2'b00) && (a <= pin_event_pkg::OFS_PINS);
  endfunction : known_addr

  // Requirement code for term t, pin p
  // Terms t and t+2 share codes
  function automatic logic [3:0] code_of(input logic [31:0] c0, input logic [31:0] c1,
                                         input int t, input int p);
    logic [63:0] all;
    all = {c1, c0};
    code_of = all[(t*8 + p) % 16 * 4 +: 4];
  endfunction : code_of

  // Pin choice per channel from the selection register
  generate
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_sel
      assign sel_pins[c] = pin_bus[sel_r[c*SW +: SW]];
    end
  endgenerate

  // Synchronise the chosen pins
  pin_sync #(
    .WIDTH (NUM_CHAN)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (sel_pins),
    .level   (pv.level),
    .rise    (pv.rise),
    .fall    (pv.fall)
  );

  // Channel and term condition evaluation
  always_comb begin
    cond_code = '0;
    edge_hit = (pv.rise & rise_en_r) | (pv.fall & fall_en_r);
    lvl_hit  = (pv.level & rise_en_r) | (~pv.level & fall_en_r);
    for (int t = 0; t < NUM_CHAN; t++) begin
      term_hit[t] = pm_term_r[t];
      for (int p = 0; p < NUM_CHAN; p++) begin
        cond_code = code_of(pm_cfg_r, pm_cfg1_r, t, p);
        case (cond_code[2:0])
          3'(pin_event_pkg::COND_HIGH):     term_hit[t] &= pv.level[p];
          3'(pin_event_pkg::COND_LOW):      term_hit[t] &= ~pv.level[p];
          3'(pin_event_pkg::COND_RISE):     term_hit[t] &= pv.rise[p];
          3'(pin_event_pkg::COND_FALL):     term_hit[t] &= pv.fall[p];
          3'(pin_event_pkg::COND_ANY_EDGE): term_hit[t] &= pv.rise[p] | pv.fall[p];
          default:                          term_hit[t] &= 1'b1;
        endcase
      end
    end
  end

  // Bus handshake and write-side decode
  // No new write while answering
  assign wr_fire  = aw_got_r && w_got_r && !bvalid_r;
  assign flag_clr = (wr_fire && awaddr_r == pin_event_pkg::OFS_STATUS)
                    ? wdata_r[NUM_CHAN-1:0] : '0;
  assign ist_clr  = (wr_fire && awaddr_r == pin_event_pkg::OFS_IRQ_CLR)
                    ? wdata_r[NUM_CHAN-1:0] : '0;

  // Next state of registers and bus
  always_comb begin
    sel_nxt     = sel_r;
    level_nxt   = level_r;
    rise_en_nxt = rise_en_r;
    fall_en_nxt = fall_en_r;
    wake_en_nxt = wake_en_r;
    pm_ctrl_nxt = pm_ctrl_r;
    pm_cfg_nxt  = pm_cfg_r;
    pm_cfg1_nxt = pm_cfg1_r;
    pm_term_nxt = pm_term_r;
    ien_nxt     = ien_r;
    aw_got_nxt  = aw_got_r;
    w_got_nxt   = w_got_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
    end
    // Perform the write in one cycle
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = known_addr(awaddr_r) ? pin_event_pkg::RESP_OKAY :
                   pin_event_pkg::RESP_SLVERR;
      case (awaddr_r)
        // Six-bit index per byte
        pin_event_pkg::OFS_SEL_LO:  sel_nxt[0 +: 4*SW]      = {wdata_r[29:24], wdata_r[21:16],
                                                               wdata_r[13:8], wdata_r[5:0]};
        pin_event_pkg::OFS_SEL_HI:  sel_nxt[4*SW +: 4*SW]   = {wdata_r[29:24], wdata_r[21:16],
                                                               wdata_r[13:8], wdata_r[5:0]};
        pin_event_pkg::OFS_LEVEL:   level_nxt   = wdata_r[NUM_CHAN-1:0];
        pin_event_pkg::OFS_RISE_EN: rise_en_nxt = wdata_r[NUM_CHAN-1:0];
        pin_event_pkg::OFS_FALL_EN: fall_en_nxt = wdata_r[NUM_CHAN-1:0];
        pin_event_pkg::OFS_WAKE_EN: wake_en_nxt = wdata_r[NUM_CHAN-1:0];
        pin_event_pkg::OFS_PM_CTRL: pm_ctrl_nxt = wdata_r[1:0];
        pin_event_pkg::OFS_PM_CFG0: pm_cfg_nxt  = wdata_r;
        pin_event_pkg::OFS_PM_CFG1: pm_cfg1_nxt = wdata_r;
        pin_event_pkg::OFS_PM_TERM: pm_term_nxt = wdata_r[NUM_CHAN-1:0];
        pin_event_pkg::OFS_IRQ_EN:  ien_nxt     = wdata_r[NUM_CHAN-1:0];
        default:                    ;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Reads answer the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = known_addr(s_axi_araddr) ? pin_event_pkg::RESP_OKAY :
                   pin_event_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        pin_event_pkg::OFS_SEL_LO:   rdata_nxt = {2'b00, sel_r[3*SW +: SW], 2'b00, sel_r[2*SW +: SW],
                                                  2'b00, sel_r[SW +: SW], 2'b00, sel_r[0 +: SW]};
        pin_event_pkg::OFS_SEL_HI:   rdata_nxt = {2'b00, sel_r[7*SW +: SW], 2'b00, sel_r[6*SW +: SW],
                                                  2'b00, sel_r[5*SW +: SW], 2'b00, sel_r[4*SW +: SW]};
        pin_event_pkg::OFS_LEVEL:    rdata_nxt = {24'h00_0000, level_r};
        pin_event_pkg::OFS_RISE_EN:  rdata_nxt = {24'h00_0000, rise_en_r};
        pin_event_pkg::OFS_FALL_EN:  rdata_nxt = {24'h00_0000, fall_en_r};
        pin_event_pkg::OFS_STATUS:   rdata_nxt = {24'h00_0000, chan_irq};
        pin_event_pkg::OFS_WAKE_EN:  rdata_nxt = {24'h00_0000, wake_en_r};
        pin_event_pkg::OFS_PM_CTRL:  rdata_nxt = {30'h0000_0000, pm_ctrl_r};
        pin_event_pkg::OFS_PM_SRC:   rdata_nxt = {24'h00_0000, term_r};
        pin_event_pkg::OFS_PM_CFG0:  rdata_nxt = pm_cfg_r;
        pin_event_pkg::OFS_PM_CFG1:  rdata_nxt = pm_cfg1_r;
        pin_event_pkg::OFS_PM_TERM:  rdata_nxt = {24'h00_0000, pm_term_r};
        pin_event_pkg::OFS_IRQ_STAT: rdata_nxt = {24'h00_0000, ist_r};
        pin_event_pkg::OFS_IRQ_EN:   rdata_nxt = {24'h00_0000, ien_r};
        pin_event_pkg::OFS_PINS:     rdata_nxt = {24'h00_0000, pv.level};
        default:                     rdata_nxt = pin_event_pkg::RST_ZERO;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Event-side next state; set wins over software clear
  always_comb begin
    // Only edges latch
    flag_nxt  = (flag_r & ~flag_clr) | (edge_hit & ~level_r);
    term_nxt  = pm_ctrl_r[0] ? term_hit : '0;
    // Pulse only as a match starts
    event_nxt = pm_ctrl_r[0] && pm_ctrl_r[1] && (|term_hit) && !(|term_r);
    ist_nxt   = (ist_r & ~ist_clr)
                | (pm_ctrl_r[0] ? term_hit : (edge_hit | (lvl_hit & level_r)));
  end

  // Register all state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r     <= '0;
      level_r   <= '0;
      rise_en_r <= '0;
      fall_en_r <= '0;
      wake_en_r <= '0;
      pm_ctrl_r <= '0;
      pm_cfg_r  <= pin_event_pkg::RST_ZERO;
      pm_cfg1_r <= pin_event_pkg::RST_ZERO;
      pm_term_r <= '0;
      flag_r    <= '0;
      ist_r     <= '0;
      ien_r     <= '0;
      event_r   <= 1'b0;
      term_r    <= '0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= pin_event_pkg::RST_ZERO;
      bvalid_r  <= 1'b0;
      bresp_r   <= pin_event_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= pin_event_pkg::RST_ZERO;
      rresp_r   <= pin_event_pkg::RESP_OKAY;
    end else begin
      sel_r     <= sel_nxt;
      level_r   <= level_nxt;
      rise_en_r <= rise_en_nxt;
      fall_en_r <= fall_en_nxt;
      wake_en_r <= wake_en_nxt;
      pm_ctrl_r <= pm_ctrl_nxt;
      pm_cfg_r  <= pm_cfg_nxt;
      pm_cfg1_r <= pm_cfg1_nxt;
      pm_term_r <= pm_term_nxt;
      flag_r    <= flag_nxt;
      ist_r     <= ist_nxt;
      ien_r     <= ien_nxt;
      event_r   <= event_nxt;
      term_r    <= term_nxt;
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // Channel lines: pattern terms in match mode, otherwise edge or level
  always_comb begin
    if (pm_ctrl_r[0]) begin
      chan_irq = term_r;
    end else begin
      chan_irq = (flag_r & ~level_r) | (lvl_hit & level_r);
    end
  end

  // Wake only from channel mode
  assign wake_req       = !pm_ctrl_r[0] && |(chan_irq & wake_en_r);
  assign cpu_wake_event = event_r;
  assign irq            = |(ist_r & ien_r);

  // Bus outputs
  // Strobes ignored, full words
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

endmodule : pin_event_unit

// File: tb/pin_event_unit_chk.sv
/*
  Port checker for the pin event unit, bound to every instance.
  Assumes one clock, aclk, and the synchronous active-low reset aresetn.
*/
`timescale 1ns/1ps
module pin_event_unit_chk #(
  parameter int NUM_CHAN = 8,
  parameter int NUM_PINS = 64
) (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Register bus
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [7:0]          s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  // Interrupt side
  input wire logic [NUM_CHAN-1:0] chan_irq,
  input wire logic                wake_req,
  input wire logic                cpu_wake_event,
  input wire logic                irq
);
  // One domain: shared clock and reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Outputs are quiet on the first edge out of reset
  AST_RESET_QUIET:
    assert property ($rose(aresetn) |-> chan_irq == '0 && !irq && !wake_req && !cpu_wake_event)
    else $error("interrupt outputs active right after reset");
  // A read answers on the next cycle
  AST_READ_LAT:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  // A write answers within two cycles of address and data taken together
  AST_WRITE_LAT:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  // Unmapped or unaligned reads give an error and zero data
  AST_READ_ERR:
    assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h3C || s_axi_araddr[1:0] != 2'b00)
      |=> s_axi_rresp == pin_event_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("bad read address not refused");
  // Read data stands until taken
  AST_READ_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  // Write response stands until taken
  AST_WRITE_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  // No new read accepted while one is pending
  AST_READ_BLOCK:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
  // Wake only comes from an active channel line
  AST_WAKE_SRC:
    assert property (wake_req |-> chan_irq != '0) else $error("wake without channel request");
  // Event notification is a single-cycle pulse
  AST_EVENT_PULSE:
    assert property (cpu_wake_event |=> !cpu_wake_event) else $error("event pulse too long");

  // Main scenarios reached
  cover property (chan_irq != '0);
  cover property (cpu_wake_event);
  cover property (irq && wake_req);
endmodule : pin_event_unit_chk

bind pin_event_unit pin_event_unit_chk #(.NUM_CHAN(NUM_CHAN), .NUM_PINS(NUM_PINS)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .chan_irq(chan_irq), .wake_req(wake_req), .cpu_wake_event(cpu_wake_event), .irq(irq));

// File: tb/pin_drive_model.sv
/*
  External pin model: drives the candidate pin vector.
  Assumes the bench changes pins through set_pins after a clock edge.
*/
`timescale 1ns/1ps
module pin_drive_model (
  // Clock
  input wire logic  aclk,
  // Pins towards the unit
  output logic [63:0] pin_bus
);
  logic [63:0] pin_r = 64'h0000_0000_0000_0000;  // Commanded levels
  logic [1:0]  noise_r = 2'b01;                  // Unselected pins that never rest

  // Pins 1 and 2 toggle every cycle; only selected pins may matter
  always @(posedge aclk) begin
    noise_r <= ~noise_r;
  end
  assign pin_bus = {pin_r[63:3], noise_r, pin_r[0]};

  // Raise or lower every pin in the mask on the next edge
  task set_pins(input logic [63:0] m, input logic v);
    @(posedge aclk);
    pin_r <= v ? (pin_r | m) : (pin_r & ~m);
  endtask : set_pins
endmodule : pin_drive_model

// File: tb/tb_top.sv
/*
  Self-checking bench for the pin event unit: AXI4-Lite tasks and scenarios.
  Assumes the pin model and the bound checker compile alongside.
*/
`timescale 1ns/1ps
module tb_top;
  logic        aclk, aresetn; // Clock and reset
  logic [63:0] pin_bus; // Pins from the model
  logic [7:0]  awaddr, araddr; // Bus addresses
  logic [31:0] wdata, rdata, rd; // Bus data
  logic [3:0]  wstrb; // Byte strobes
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rs; // Response codes
  logic [7:0]  chan_irq; // Channel lines
  logic        wake_req, cpu_wake_event, irq;
  logic        pm_on, term_seen, wake_bad; // Match-mode monitors
  int          fail_count, cmp_count, ev_cnt;

  // Clock, 5 ns period
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  pin_drive_model pins (.aclk(aclk), .pin_bus(pin_bus));

  pin_event_unit dut (
    .aclk(aclk), .aresetn(aresetn), .pin_bus(pin_bus),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chan_irq(chan_irq), .wake_req(wake_req), .cpu_wake_event(cpu_wake_event), .irq(irq));

  // Compare a word
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  // Compare a response code
  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  // Write: address and data offered together, each released when taken
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    if (n >= 50) fail_count++;
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  // Read: address held until taken, data taken with rvalid
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    if (n >= 50) fail_count++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Write expecting an OKAY answer
  task wr_ok(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
    chk_resp(rs, pin_event_pkg::RESP_OKAY);
  endtask : wr_ok

  // Let pin changes cross the synchroniser
  task settle;
    repeat (6) @(posedge aclk);
  endtask : settle

  // Verdict and end of run
  task test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // Match-mode monitors
  always @(posedge aclk) begin
    if (pm_on) begin
      ev_cnt    += cpu_wake_event;
      term_seen |= chan_irq[0];
      wake_bad  |= wake_req;
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    test_done;
  end

  // Scenarios
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    {pm_on, term_seen, wake_bad} = 3'b000;
    {fail_count, cmp_count, ev_cnt} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 64; a += 4) begin
      axi_rd(a[7:0], rd, rs);
      chk_word(rd, pin_event_pkg::RST_ZERO);
    end
    axi_rd(8'h40, rd, rs);
    chk_resp(rs, pin_event_pkg::RESP_SLVERR);
    axi_wr(8'h06, 32'hFFFF_FFFF, rs);
    chk_resp(rs, pin_event_pkg::RESP_SLVERR);
    // Channels 0..7 on pins 5,9,20,33,40,50,60,63
    wr_ok(pin_event_pkg::OFS_SEL_LO, 32'h2114_0905);
    wr_ok(pin_event_pkg::OFS_SEL_HI, 32'h3F3C_3228);
    wr_ok(pin_event_pkg::OFS_LEVEL, 32'h0000_0018);
    wr_ok(pin_event_pkg::OFS_RISE_EN, 32'h0000_000D);
    wr_ok(pin_event_pkg::OFS_FALL_EN, 32'h0000_0016);
    wr_ok(pin_event_pkg::OFS_WAKE_EN, 32'h0000_0001);
    axi_rd(pin_event_pkg::OFS_SEL_LO, rd, rs);
    chk_word(rd, 32'h2114_0905);
    settle;
    chk_word({24'h0, chan_irq}, 32'h0000_0010);
    pins.set_pins(64'h0000_0102_0010_0220, 1'b1);
    settle;
    chk_word({24'h0, chan_irq}, 32'h0000_000D);
    chk_word({31'h0, wake_req}, 32'h0000_0001);
    pins.set_pins(64'h0000_0002_0010_0220, 1'b0);
    settle;
    chk_word({24'h0, chan_irq}, 32'h0000_0007);
    axi_rd(pin_event_pkg::OFS_STATUS, rd, rs);
    chk_word(rd, 32'h0000_0007);
    chk_word({31'h0, irq}, 32'h0000_0000);
    wr_ok(pin_event_pkg::OFS_IRQ_EN, 32'hFFFF_FFFF);
    chk_word({31'h0, irq}, 32'h0000_0001);
    wr_ok(pin_event_pkg::OFS_STATUS, 32'h0000_00FF);
    wr_ok(pin_event_pkg::OFS_IRQ_CLR, 32'hFFFF_FFFF);
    settle;
    chk_word({24'h0, chan_irq}, 32'h0000_0000);
    chk_word({31'h0, irq}, 32'h0000_0000);
    axi_rd(pin_event_pkg::OFS_IRQ_STAT, rd, rs);
    chk_word(rd, 32'h0000_0000);
    // Term 0: slot 0 high, a rise on slot 1, slot 2 low
    wr_ok(pin_event_pkg::OFS_PM_CFG0, 32'h0000_0231);
    wr_ok(pin_event_pkg::OFS_PM_TERM, 32'h0000_0001);
    wr_ok(pin_event_pkg::OFS_PM_CTRL, 32'h0000_0003);
    pm_on = 1'b1;
    pins.set_pins(64'h0000_0000_0000_0200, 1'b1);
    settle;
    chk_word(ev_cnt, 32'h0000_0000);
    pins.set_pins(64'h0000_0000_0000_0200, 1'b0);
    pins.set_pins(64'h0000_0000_0000_0020, 1'b1);
    settle;
    pins.set_pins(64'h0000_0000_0000_0200, 1'b1);
    settle;
    chk_word(ev_cnt, 32'h0000_0001);
    chk_word({31'h0, term_seen}, 32'h0000_0001);
    chk_word({31'h0, wake_bad}, 32'h0000_0000);
    test_done;
  end
endmodule : tb_top
